/* File: src/loop_cfg_defines.vh */
// register offsets, field positions and timing counts of the loop configuration bank
`ifndef LOOP_CFG_DEFINES_VH
`define LOOP_CFG_DEFINES_VH
`define LOOP_CFG_ONE_IDX 8'h89
`define LOOP_CFG_TWO_IDX 8'h8A
`define LOOP_CFG_ONE_ADDR 10'h224
`define LOOP_CFG_TWO_ADDR 10'h228
`define LOOP_CFG_ONE_RST 32'h0000_0000
`define LOOP_CFG_TWO_RST 32'h0000_0000
`define LOOP_CFG_ONE_MASK 32'h0000_7FFF
`define F_MOD_SEL 14
`define F_GATE_HI 13
`define F_GATE_LO 12
`define F_DIV_HI 11
`define F_DIV_LO 8
`define F_POLICY 7
`define F_EMF_HI 6
`define F_EMF_LO 4
`define F_SURGE 3
`define F_DTC 2
`define F_SPD_OFF 1
`define F_RECIRC_SUB 0
`define F_PARITY 31
`define F_STOP_HI 30
`define F_STOP_LO 28
`define F_BRK_HI 27
`define F_BRK_LO 24
`define F_SPIN_HI 23
`define F_SPIN_LO 20
`define F_BTHR_HI 19
`define F_BTHR_LO 16
`define F_RES_HI 15
`define F_RES_LO 8
`define F_IND_HI 7
`define F_IND_LO 0
`define STOP_HIZ 3'h0
`define STOP_RECIRC 3'h1
`define STOP_LS_BRAKE 3'h2
`define STOP_HS_BRAKE 3'h3
`define STOP_SPIN_DOWN 3'h4
`define STOP_ALIGN 3'h5
`define BRK_TIME_US_0 32'd100
`define BRK_TIME_US_2 32'd250
`define BRK_TIME_US_3 32'd500
`define BRK_TIME_US_4 32'd1000
`define BRK_TIME_US_5 32'd5000
`define BRK_TIME_US_6 32'd10000
`define BRK_TIME_US_7 32'd50000
`define BRK_TIME_US_8 32'd100000
`define BRK_TIME_US_9 32'd250000
`define BRK_TIME_US_A 32'd500000
`define BRK_TIME_US_B 32'd1000000
`define BRK_TIME_US_C 32'd2500000
`define BRK_TIME_US_D 32'd5000000
`define BRK_TIME_US_E 32'd10000000
`define BRK_TIME_US_F 32'd15000000
`define CLK_MHZ 32'd250
`define US_TICK_CYCLES 8'd250
`define SPIN_PCT_X10 {16'd25, 16'd50, 16'd100, 16'd150, 16'd200, 16'd250, 16'd300, \
    16'd350, 16'd400, 16'd450, 16'd500, 16'd600, 16'd700, 16'd800, 16'd900, 16'd1000}
`endif

/* File: src/motor_loop_config_regs.v */
// loop configuration register bank with axi4-lite slave
// Behaviour
// - bit 14 selects continuous (0) or discontinuous (1) space vector modulation.
// - bits 13-12 gate speed pulse: both loops, closed only, open first try.
// - bits 11-8 divide speed pulse by one for 0 and 1, else by code.
// - bit 7 keeps pulse while driven (0) or until emf below threshold (1).
// - bits 6-4 pick emf threshold 1,2,5,10,20,30 mV; codes 6,7 unused.
// - bit 3 enables anti-surge.
// - bit 2 enables deadtime compensation.
// - bit 1 set turns the speed loop off.
// - bits 30-28 pick stop method among six; codes 6,7 unused.
// - recirculation in align or open loop becomes hi-z or low-side brake per bit 0.
// - bits 27-24 pick brake time from 0.1 ms up to 15000 ms.
// - second register at 8Ah resets zero, bit 31 parity, all fields read-write.
// - bits 23-20 pick spin-down threshold from 100% down to 2.5%.
// - bits 19-16 set brake speed threshold percentage.
`include "loop_cfg_defines.vh"
module motor_loop_config_regs (
    input wire i_core_clk, // core clock 250 MHz
    input wire i_srst, // synchronous reset, high
    input wire [9:0] i_awaddr, // write address
    input wire i_awvalid, // write address valid
    output reg o_awready, // write address ready
    input wire [31:0] i_wdata, // write data
    input wire [3:0] i_wstrb, // write byte enables
    input wire i_wvalid, // write data valid
    output reg o_wready, // write data ready
    output reg [1:0] o_bresp, // write response
    output reg o_bvalid, // write response valid
    input wire i_bready, // write response ready
    input wire [9:0] i_araddr, // read address
    input wire i_arvalid, // read address valid
    output reg o_arready, // read address ready
    output reg [31:0] o_rdata, // read data
    output reg [1:0] o_rresp, // read response
    output reg o_rvalid, // read data valid
    input wire i_rready, // read data ready
    input wire i_raw_pulse, // commutation pulse
    input wire i_closed_loop, // closed loop state
    input wire i_open_loop, // open loop state
    input wire i_align, // align state
    input wire i_first_try, // first start attempt
    input wire i_driven, // motor driven
    input wire [15:0] i_emf_uv, // back-emf magnitude, microvolts
    input wire i_stop_req, // stop start pulse
    input wire [15:0] i_speed_pct_x10, // speed in 0.1% of max
    output reg o_speed_pulse_out, // gated divided speed pulse
    output reg o_mod_discontinuous, // discontinuous modulation
    output reg o_anti_surge_enable, // anti-surge on
    output reg o_deadtime_comp_en, // deadtime compensation on
    output reg o_speed_loop_on, // speed loop running
    output reg [2:0] o_stop_mode, // effective stop method
    output reg o_braking, // brake window active
    output reg o_spin_down_below, // speed below spin-down limit
    output reg o_brake_speed_below, // speed below brake threshold
    output reg [15:0] o_emf_thr_uv, // emf threshold microvolts
    output reg [7:0] o_winding_resistance_param, // resistance parameter
    output reg [7:0] o_winding_inductance_param // inductance parameter
);
    reg [31:0] loop_config_one_r;
    reg [31:0] loop_config_two_r;
    reg [9:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;
    reg [15:0] emf_thr;
    reg [15:0] spin_lim;
    reg [15:0] brk_lim;
    wire [255:0] pct_table = `SPIN_PCT_X10;
    wire pulse_w;
    wire [2:0] stop_w;
    wire braking_w;
    wire [31:0] wmask;
    wire do_write = aw_have_r && w_have_r && !o_bvalid;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : lane
            assign wmask[g*8+7:g*8] = {8{w_strb_r[g]}};
        end
    endgenerate

    // emf threshold lookup; unused codes hold the largest threshold
    always @* begin
        case (loop_config_one_r[`F_EMF_HI:`F_EMF_LO])
            3'h0: emf_thr = 16'd1000;
            3'h1: emf_thr = 16'd2000;
            3'h2: emf_thr = 16'd5000;
            3'h3: emf_thr = 16'd10000;
            3'h4: emf_thr = 16'd20000;
            default: emf_thr = 16'd30000;
        endcase
        // largest percentage sits in the low word, so the code indexes words directly
        spin_lim = pct_table[{loop_config_two_r[`F_SPIN_HI:`F_SPIN_LO], 4'h0} +: 16];
        brk_lim = pct_table[{loop_config_two_r[`F_BTHR_HI:`F_BTHR_LO], 4'h0} +: 16];
    end

    speed_pulse_gen u_pulse (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_raw_pulse(i_raw_pulse),
        .i_divider(loop_config_one_r[`F_DIV_HI:`F_DIV_LO]),
        .i_gating(loop_config_one_r[`F_GATE_HI:`F_GATE_LO]),
        .i_policy(loop_config_one_r[`F_POLICY]),
        .i_closed_loop(i_closed_loop),
        .i_open_loop(i_open_loop),
        .i_first_try(i_first_try),
        .i_driven(i_driven),
        .i_emf_above(i_emf_uv >= emf_thr),
        .o_pulse(pulse_w)
    );

    stop_brake_timer u_stop (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_stop_sel(loop_config_two_r[`F_STOP_HI:`F_STOP_LO]),
        .i_recirc_sub(loop_config_one_r[`F_RECIRC_SUB]),
        .i_slow_state(i_align | i_open_loop),
        .i_brake_code(loop_config_two_r[`F_BRK_HI:`F_BRK_LO]),
        .i_stop_req(i_stop_req),
        .o_stop_mode(stop_w),
        .o_braking(braking_w)
    );

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 10'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= 2'b00;
            loop_config_one_r <= `LOOP_CFG_ONE_RST;
            loop_config_two_r <= `LOOP_CFG_TWO_RST;
        end else begin
            o_awready <= !aw_have_r && !(i_awvalid && o_awready);
            o_wready <= !w_have_r && !(i_wvalid && o_wready);
            if (i_awvalid && o_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= i_wdata;
                w_strb_r <= i_wstrb;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= 2'b00;
                if ({aw_addr_r[9:2], 2'b00} == `LOOP_CFG_ONE_ADDR) begin
                    loop_config_one_r <= ((loop_config_one_r & ~wmask) | (w_data_r & wmask))
                        & `LOOP_CFG_ONE_MASK;
                end else if ({aw_addr_r[9:2], 2'b00} == `LOOP_CFG_TWO_ADDR) begin
                    loop_config_two_r <= (loop_config_two_r & ~wmask) | (w_data_r & wmask);
                end else begin
                    o_bresp <= 2'b10;
                end
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= 2'b00;
        end else begin
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp <= 2'b00;
                if ({i_araddr[9:2], 2'b00} == `LOOP_CFG_ONE_ADDR) begin
                    o_rdata <= loop_config_one_r;
                end else if ({i_araddr[9:2], 2'b00} == `LOOP_CFG_TWO_ADDR) begin
                    o_rdata <= loop_config_two_r;
                end else begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= 2'b10;
                end
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // outputs registered once more so every top port comes from a flop
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            o_speed_pulse_out <= 1'b0;
            o_mod_discontinuous <= 1'b0;
            o_anti_surge_enable <= 1'b0;
            o_deadtime_comp_en <= 1'b0;
            o_speed_loop_on <= 1'b1;
            o_stop_mode <= `STOP_HIZ;
            o_braking <= 1'b0;
            o_spin_down_below <= 1'b0;
            o_brake_speed_below <= 1'b0;
            o_emf_thr_uv <= 16'd1000;
            o_winding_resistance_param <= 8'h00;
            o_winding_inductance_param <= 8'h00;
        end else begin
            o_speed_pulse_out <= pulse_w;
            o_mod_discontinuous <= loop_config_one_r[`F_MOD_SEL];
            o_anti_surge_enable <= loop_config_one_r[`F_SURGE];
            o_deadtime_comp_en <= loop_config_one_r[`F_DTC];
            o_speed_loop_on <= !loop_config_one_r[`F_SPD_OFF];
            o_stop_mode <= stop_w;
            o_braking <= braking_w;
            o_spin_down_below <= i_speed_pct_x10 < spin_lim;
            o_brake_speed_below <= i_speed_pct_x10 < brk_lim;
            o_emf_thr_uv <= emf_thr;
            o_winding_resistance_param <= loop_config_two_r[`F_RES_HI:`F_RES_LO];
            o_winding_inductance_param <= loop_config_two_r[`F_IND_HI:`F_IND_LO];
        end
    end
endmodule

/* File: src/speed_pulse_gen.v */
// speed pulse divider and output gating
`include "loop_cfg_defines.vh"
module speed_pulse_gen (
    input wire i_core_clk, // core clock
    input wire i_srst, // synchronous reset
    input wire i_raw_pulse, // one-cycle commutation pulse
    input wire [3:0] i_divider, // divider code
    input wire [1:0] i_gating, // gating code
    input wire i_policy, // active policy
    input wire i_closed_loop, // motor in closed loop
    input wire i_open_loop, // motor in open loop
    input wire i_first_try, // first start attempt
    input wire i_driven, // motor driven
    input wire i_emf_above, // emf above threshold
    output reg o_pulse // divided gated output
);
    reg [3:0] cnt_r;
    reg allow;
    wire [3:0] div_eff = (i_divider < 4'h2) ? 4'h1 : i_divider;
    always @* begin
        case (i_gating)
            2'h0: allow = i_closed_loop | i_open_loop;
            2'h1: allow = i_closed_loop;
            2'h2: allow = i_closed_loop | (i_open_loop & i_first_try);
            default: allow = 1'b0;
        endcase
        if (i_policy ? !i_emf_above : !i_driven) begin
            allow = 1'b0;
        end
    end
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_r <= 4'h0;
            o_pulse <= 1'b0;
        end else if (!allow) begin
            cnt_r <= 4'h0;
            o_pulse <= 1'b0;
        end else if (i_raw_pulse) begin
            if (cnt_r + 4'h1 >= div_eff) begin
                cnt_r <= 4'h0;
                o_pulse <= ~o_pulse;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

/* File: src/stop_brake_timer.v */
// stop method resolution and brake duration timer
`include "loop_cfg_defines.vh"
module stop_brake_timer (
    input wire i_core_clk, // core clock
    input wire i_srst, // synchronous reset
    input wire [2:0] i_stop_sel, // stop method code
    input wire i_recirc_sub, // substitute choice
    input wire i_slow_state, // align or open loop
    input wire [3:0] i_brake_code, // brake duration code
    input wire i_stop_req, // one-cycle stop start
    output reg [2:0] o_stop_mode, // effective method
    output reg o_braking // brake window active
);
    reg [31:0] us_left_r;
    reg [7:0] tick_r;
    reg [31:0] dur_us;
    reg [2:0] mode;
    always @* begin
        case (i_brake_code)
            4'h2: dur_us = `BRK_TIME_US_2;
            4'h3: dur_us = `BRK_TIME_US_3;
            4'h4: dur_us = `BRK_TIME_US_4;
            4'h5: dur_us = `BRK_TIME_US_5;
            4'h6: dur_us = `BRK_TIME_US_6;
            4'h7: dur_us = `BRK_TIME_US_7;
            4'h8: dur_us = `BRK_TIME_US_8;
            4'h9: dur_us = `BRK_TIME_US_9;
            4'hA: dur_us = `BRK_TIME_US_A;
            4'hB: dur_us = `BRK_TIME_US_B;
            4'hC: dur_us = `BRK_TIME_US_C;
            4'hD: dur_us = `BRK_TIME_US_D;
            4'hE: dur_us = `BRK_TIME_US_E;
            4'hF: dur_us = `BRK_TIME_US_F;
            default: dur_us = `BRK_TIME_US_0;
        endcase
        mode = (i_stop_sel > `STOP_ALIGN) ? `STOP_HIZ : i_stop_sel;
        if (mode == `STOP_RECIRC && i_slow_state) begin
            mode = i_recirc_sub ? `STOP_LS_BRAKE : `STOP_HIZ;
        end
    end
    always @(posedge i_core_clk) begin
        if (i_srst) begin
            us_left_r <= 32'h0000_0000;
            tick_r <= 8'h00;
            o_braking <= 1'b0;
            o_stop_mode <= `STOP_HIZ;
        end else begin
            o_stop_mode <= mode;
            if (i_stop_req) begin
                us_left_r <= dur_us;
                tick_r <= 8'h00;
                o_braking <= 1'b1;
            end else if (o_braking) begin
                if (tick_r == `US_TICK_CYCLES - 8'd1) begin
                    tick_r <= 8'h00;
                    if (us_left_r == 32'h0000_0001) begin
                        o_braking <= 1'b0;
                    end
                    us_left_r <= us_left_r - 32'h0000_0001;
                end else begin
                    tick_r <= tick_r + 8'h01;
                end
            end
        end
    end
endmodule

/* File: tb/motor_loop_config_regs_props.sv */
// bus and output checks for the loop configuration bank
module motor_loop_config_regs_props (
    input wire logic i_core_clk, // core clock
    input wire logic i_srst, // sync reset
    input wire logic i_awvalid, // aw valid
    input wire logic o_awready, // aw ready
    input wire logic i_wvalid, // w valid
    input wire logic o_wready, // w ready
    input wire logic o_bvalid, // b valid
    input wire logic i_bready, // b ready
    input wire logic [1:0] o_bresp, // b response
    input wire logic i_arvalid, // ar valid
    input wire logic o_arready, // ar ready
    input wire logic o_rvalid, // r valid
    input wire logic i_rready, // r ready
    input wire logic [31:0] o_rdata, // read data
    input wire logic [1:0] o_rresp, // read response
    input wire logic i_align, // align state
    input wire logic i_open_loop, // open loop state
    input wire logic [15:0] i_speed_pct_x10, // speed
    input wire logic [2:0] o_stop_mode, // stop method
    input wire logic [15:0] o_emf_thr_uv, // emf threshold
    input wire logic o_spin_down_below, // below spin-down limit
    input wire logic o_brake_speed_below // below brake limit
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);
    a_write_answer: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("no write answer");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("no read answer");
    a_bresp_hold: assert property (
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("b dropped");
    a_rdata_hold: assert property (
        o_rvalid && !i_rready |=> o_rvalid && $stable({o_rresp, o_rdata})) else $error("r dropped");
    a_ar_blocked: assert property (o_rvalid |-> !o_arready)
        else $error("ar accepted during r");
    a_emf_table: assert property (
        o_emf_thr_uv inside {16'd1000, 16'd2000, 16'd5000, 16'd10000, 16'd20000, 16'd30000})
        else $error("emf threshold off table");
    a_stop_legal: assert property (o_stop_mode <= 3'h5)
        else $error("stop mode unused code");
    a_slow_no_recirc: assert property ((i_align || i_open_loop) [*4] |-> o_stop_mode != 3'h1)
        else $error("recirculation in slow state");
    a_spin_floor: assert property ((i_speed_pct_x10 < 16'd25) [*3] |-> o_spin_down_below)
        else $error("spin-down flag low at tiny speed");
    a_brake_ceiling: assert property (
        (i_speed_pct_x10 >= 16'd1000) [*3] |-> !o_brake_speed_below)
        else $error("brake flag at full");
endmodule
bind motor_loop_config_regs motor_loop_config_regs_props motor_loop_config_regs_props_i (.*);

/* File: tb/motor_loop_config_regs_tb.sv */
// self-checking bench for the loop configuration bank
`include "loop_cfg_defines.vh"
module motor_loop_config_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [9:0] i_awaddr = 10'h000;
    logic [9:0] i_araddr = 10'h000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic i_closed_loop = 1'b1, i_open_loop = 1'b0, i_align = 1'b0, i_first_try = 1'b0;
    logic i_driven = 1'b1, i_stop_req = 1'b0, go = 1'b0;
    logic [15:0] i_emf_uv = 16'h0000;
    logic [15:0] i_speed_pct_x10 = 16'h0000;
    logic [7:0] nb = 8'h00;
    wire [7:0] tog;
    wire i_raw_pulse, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_speed_pulse_out;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    wire o_mod_discontinuous, o_anti_surge_enable, o_deadtime_comp_en, o_speed_loop_on;
    wire o_braking, o_spin_down_below, o_brake_speed_below;
    wire [2:0] o_stop_mode;
    wire [15:0] o_emf_thr_uv;
    wire [7:0] o_winding_resistance_param, o_winding_inductance_param;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [33:0] exp_q[$];
    logic [31:0] seed = 32'h9f1d_cca0;
    logic [31:0] old, m;
    logic [15:0] thr[8] = '{16'd1000, 16'd2000, 16'd5000, 16'd10000, 16'd20000, 16'd30000,
        16'd30000, 16'd30000};
    motor_loop_config_regs motor_loop_config_regs_i (.*);
    motor_partner motor_partner_i (.i_core_clk(i_core_clk), .i_go(go), .i_burst(nb),
        .i_speed_pulse_out(o_speed_pulse_out), .o_raw_pulse(i_raw_pulse), .o_toggles(tog));
    always #2 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stall(input int n);
        if (n == 100) begin
            check("bus_wait", 1'b0, 1'b1);
            conclude();
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] eb);
        int n;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        // bready sometimes waits for bvalid so the response hold gets exercised
        i_bready <= d[0];
        for (n = 0; n < 100 && (i_awvalid || i_wvalid || o_bvalid !== 1'b1 || !i_bready);
            n++) begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
            if (o_bvalid && !i_bready) i_bready <= 1'b1;
        end
        stall(n);
        check("bresp", o_bresp, eb);
        i_bready <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic rd(input logic [9:0] a, input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= a[2];
        for (n = 0; n < 100 && (i_arvalid || o_rvalid !== 1'b1 || !i_rready); n++) begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid && !i_rready) i_rready <= 1'b1;
        end
        stall(n);
        i_rready <= 1'b0;
        @(posedge i_core_clk);
    endtask
    // read results are matched in arrival order against the notes of rd
    always @(posedge i_core_clk) begin
        if (o_rvalid === 1'b1 && i_rready) begin
            if (exp_q.size() == 0)
                check("rdata_extra", 1'b1, 1'b0);
            else
                check("rdata", {o_rresp, o_rdata}, exp_q.pop_front());
        end
    end
    task automatic pul(input logic [15:0] c1, input logic [4:0] st, input logic [7:0] n,
        input logic [7:0] e);
        {i_closed_loop, i_open_loop, i_first_try, i_driven} <= st[4:1];
        i_emf_uv <= st[0] ? 16'd5000 : 16'd1500;
        wr(`LOOP_CFG_ONE_ADDR, {16'h0000, c1}, 4'hF, 2'b00);
        go <= 1'b1;
        nb <= n;
        @(posedge i_core_clk);
        go <= 1'b0;
        repeat (4 * n + 12) @(posedge i_core_clk);
        check("pulse_toggles", tog, e);
    endtask
    initial begin
        repeat (5) @(posedge i_core_clk);
        i_srst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        check("speed_loop_on", o_speed_loop_on, 1'b1);
        rd(`LOOP_CFG_ONE_ADDR, {2'b00, `LOOP_CFG_ONE_RST});
        rd(`LOOP_CFG_TWO_ADDR, {2'b00, `LOOP_CFG_TWO_RST});
        rd(10'h3F0, {2'b10, 32'h0000_0000});
        wr(10'h3F0, seed, 4'hF, 2'b10);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(`LOOP_CFG_TWO_ADDR, seed, 4'hF, 2'b00);
            check("res", o_winding_resistance_param, seed[15:8]);
            check("ind", o_winding_inductance_param, seed[7:0]);
            old = seed;
            seed = xs(seed);
            m = {{8{seed[3]}}, {8{seed[2]}}, {8{seed[1]}}, {8{seed[0]}}};
            wr(`LOOP_CFG_TWO_ADDR, ~old, seed[3:0], 2'b00);
            rd(`LOOP_CFG_TWO_ADDR, {2'b00, (old & ~m) | (~old & m)});
            wr(`LOOP_CFG_ONE_ADDR, seed, 4'hF, 2'b00);
            rd(`LOOP_CFG_ONE_ADDR, {2'b00, seed & `LOOP_CFG_ONE_MASK});
            check("mod", o_mod_discontinuous, seed[14]);
            check("surge", o_anti_surge_enable, seed[3]);
            check("dtc", o_deadtime_comp_en, seed[2]);
            check("speed_loop_on", o_speed_loop_on, !seed[1]);
        end
        pul(16'h0000, 5'b10010, 8'd4, 8'd4);
        pul(16'h0100, 5'b10010, 8'd4, 8'd4);
        pul(16'h0200, 5'b10010, 8'd8, 8'd4);
        pul(16'h0300, 5'b10010, 8'd12, 8'd4);
        pul(16'h0F00, 5'b10010, 8'd60, 8'd4);
        pul(16'h1000, 5'b01010, 8'd4, 8'd0);
        pul(16'h1000, 5'b10010, 8'd4, 8'd4);
        pul(16'h2000, 5'b01110, 8'd4, 8'd4);
        pul(16'h2000, 5'b01010, 8'd4, 8'd0);
        pul(16'h0000, 5'b01010, 8'd4, 8'd4);
        pul(16'h3000, 5'b10010, 8'd4, 8'd0);
        pul(16'h0000, 5'b10000, 8'd4, 8'd0);
        pul(16'h0090, 5'b10001, 8'd4, 8'd4);
        pul(16'h0090, 5'b10010, 8'd4, 8'd0);
        for (int c = 0; c < 8; c++) begin
            wr(`LOOP_CFG_ONE_ADDR, c << 4, 4'hF, 2'b00);
            check("emf_thr", o_emf_thr_uv, thr[c]);
            wr(`LOOP_CFG_TWO_ADDR, c << 28, 4'hF, 2'b00);
            check("stop_mode", o_stop_mode, (c < 6) ? c : `STOP_HIZ);
        end
        for (int c = 0; c < 4; c++) begin
            {i_open_loop, i_align} <= (c < 2) ? 2'b01 : 2'b10;
            wr(`LOOP_CFG_TWO_ADDR, {4'h1, 28'h000_0000}, 4'hF, 2'b00);
            wr(`LOOP_CFG_ONE_ADDR, c & 1, 4'hF, 2'b00);
            check("slow_stop", o_stop_mode, c[0] ? `STOP_LS_BRAKE : `STOP_HIZ);
        end
        {i_open_loop, i_align} <= 2'b00;
        wr(`LOOP_CFG_TWO_ADDR, {4'h2, 4'h0, 24'h00_0000}, 4'hF, 2'b00);
        i_stop_req <= 1'b1;
        @(posedge i_core_clk);
        i_stop_req <= 1'b0;
        // 0.1 ms at 250 cycles per microsecond, tick phase allows one tick of slack
        repeat (24700) @(posedge i_core_clk);
        check("braking_on", o_braking, 1'b1);
        repeat (560) @(posedge i_core_clk);
        check("braking_off", o_braking, 1'b0);
        wr(`LOOP_CFG_TWO_ADDR, 32'h00F5_0000, 4'hF, 2'b00);
        foreach (thr[k]) begin
            i_speed_pct_x10 <= (k < 4) ? 16'd24 + k[0] : 16'd499 + k[0];
            repeat (4) @(posedge i_core_clk);
            if (k < 4)
                check("spin_below", o_spin_down_below, !k[0]);
            else
                check("brake_below", o_brake_speed_below, !k[0]);
        end
        i_speed_pct_x10 <= 16'd1000 + seed[7:0];
        repeat (4) @(posedge i_core_clk);
        check("brake_full", o_brake_speed_below, 1'b0);
        check("spin_full", o_spin_down_below, 1'b0);
        conclude();
    end
endmodule

/* File: tb/motor_partner.sv */
// far-side model: sends raw speed events, counts edges of the divided pulse
module motor_partner (
    input wire logic i_core_clk, // core clock
    input wire logic i_go, // start a burst, clear the count
    input wire logic [7:0] i_burst, // raw events to send
    input wire logic i_speed_pulse_out, // divided pulse from the block
    output logic o_raw_pulse, // one-cycle raw event
    output logic [7:0] o_toggles // edges seen since i_go
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_r = 8'h00;
    logic [1:0] gap_r = 2'h0;
    logic prev_r = 1'b0;
    initial o_raw_pulse = 1'b0;
    initial o_toggles = 8'h00;
    always @(posedge i_core_clk) begin
        prev_r <= i_speed_pulse_out;
        o_raw_pulse <= 1'b0;
        gap_r <= gap_r + 2'h1;
        if (i_go) begin
            left_r <= i_burst;
            o_toggles <= 8'h00;
        end else begin
            if (prev_r !== i_speed_pulse_out)
                o_toggles <= o_toggles + 8'h01;
            // events spaced out: a real rotor never commutates every cycle
            if (left_r != 8'h00 && gap_r == 2'h0) begin
                o_raw_pulse <= 1'b1;
                left_r <= left_r - 8'h01;
            end
        end
    end
endmodule
